// [bench/fm_tone_oscillator_tb.sv]
// Self-checking bench for the FM tone oscillator
`timescale 1ns/10ps
`include "fmtone_map.svh"
module fm_tone_oscillator_tb;
    // ************************************
    // Stimulus and observation
    // ************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic out_valid;
    logic out_ready = 1'b1;
    logic [15:0] out_sample;
    logic [31:0] out_freq;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic rerr;
    logic [15:0] ws;
    logic [31:0] wf;
    logic [31:0] prev;

    fmtone_osc uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .out_valid(out_valid), .out_ready(out_ready), .out_sample(out_sample), .out_freq(out_freq));

    // Clock at 250 MHz
    always #2 pclk = ~pclk;

    // Cycle ceiling against hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            error_cnt++;
            final_report();
        end
    end

    // ************************************
    // Shared tasks
    // ************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Next word accepted on the stream
    task get_word();
        @(posedge pclk);
        while (!(out_valid === 1'b1 && out_ready === 1'b1)) @(posedge pclk);
        ws = out_sample;
        wf = out_freq;
    endtask

    // Start a tone, then flush words made before it
    task tone(input logic [31:0] ctrl, input logic [31:0] start);
        apb(1'b1, `FMT_CTRL_OFF, ctrl);
        apb(1'b1, `FMT_START_OFF, start);
        apb(1'b1, `FMT_CMD_OFF, 32'h0000_0001);
        repeat (8) get_word();
    endtask

    // ************************************
    // Scenarios
    // ************************************
    task t_regs();
        apb(1'b0, `FMT_STATUS_OFF, 32'h0);
        check(rd[31], 1'b1);
        repeat (1600) @(posedge pclk);
        apb(1'b0, `FMT_GAIN_OFF, 32'h0);
        check(rd, 32'h0000_4000);
        apb(1'b0, `FMT_START_OFF, 32'h0);
        check(rd, 32'h0000_ffff);
        apb(1'b0, 12'h040, 32'h0);
        check(rd, 32'h0000_0000);
        check(rerr, 1'b1);
        apb(1'b1, 12'h042, 32'h1234_5678);
        check(rerr, 1'b1);
    endtask

    // Centre, minus and plus delta from loaded table values
    task t_table();
        apb(1'b1, `FMT_SRDIV_OFF, 32'h0000_0008);
        apb(1'b1, `FMT_CENTER_OFF, 32'h0000_03e8);
        apb(1'b1, `FMT_DELTA_OFF, 32'h0000_00c8);
        apb(1'b1, `FMT_RATE_OFF, 32'h0);
        tone(32'h0000_0004, 32'h0000_00c0);
        check(wf, 32'h0000_03e8);
        apb(1'b1, `FMT_TBLADDR_OFF, 32'h0000_050a);
        apb(1'b1, `FMT_TBLDATA_OFF, 32'h0000_8000);
        apb(1'b1, `FMT_TBLDATA_OFF, 32'h0000_7fff);
        apb(1'b1, `FMT_TBLDATA_OFF, 32'h0000_4000);
        tone(32'h0000_000b, 32'h0000_000a);
        check(wf, 32'h0000_0320);
        apb(1'b0, `FMT_STATUS_OFF, 32'h0);
        check(rd[23:16], 8'h0a);
        tone(32'h0000_000b, 32'h0000_000b);
        check(wf, 32'h0000_04b0);
        tone(32'h0000_000b, 32'h0000_ffff);
        check(wf, 32'h0000_04b0);
        tone(32'h0000_000b, 32'h0000_000c);
        check(wf, 32'h0000_044c);
        tone(32'h0000_000b, 32'h0000_000d);
        check(wf, 32'h0000_03e8);
    endtask

    // Triangle extremes, gain and stalled stream
    task t_tri_gain();
        tone(32'h0000_0005, 32'h0000_00c0);
        check(ws, 16'h8000);
        check(wf, 32'h0000_0320);
        tone(32'h0000_0005, 32'h0000_0040);
        check(ws, 16'h7fff);
        check(wf, 32'h0000_04b0);
        apb(1'b1, `FMT_GAIN_OFF, 32'h0000_2000);
        tone(32'h0000_0005, 32'h0000_00c0);
        check(ws, 16'hc000);
        @(posedge pclk);
        out_ready <= 1'b0;
        repeat (80) @(posedge pclk);
        check(out_valid, 1'b1);
        out_ready <= 1'b1;
    endtask

    // Rate stepping and sweep direction
    task t_rate();
        apb(1'b1, `FMT_RATE_OFF, 32'h8000_0000);
        tone(32'h0000_0005, 32'h0000_00c0);
        prev = wf;
        get_word();
        check(prev ^ wf, 32'h0000_0320 ^ 32'h0000_04b0);
        apb(1'b1, `FMT_RATE_OFF, 32'h0100_0000);
        tone(32'h0000_0005, 32'h0000_00c0);
        repeat (6) begin
            prev = wf;
            get_word();
            check(wf > prev, 1'b1);
        end
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `FMT_CTRL_OFF, 32'h0);
        check(rd, 32'h0000_0000);
    endtask

    task final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_table();
        t_tri_gain();
        t_rate();
        final_report();
    end
endmodule

// [bench/fmtone_osc_monitor.sv]
// Port checker for the FM tone oscillator
`timescale 1ns/10ps
`include "fmtone_map.svh"
module fmtone_osc_monitor #(
    parameter int FIFO_DEPTH = 4,
    parameter int FRAC_BITS = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sample stream
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [15:0] out_sample,
    input wire logic [31:0] out_freq
);
    // ************************************
    // Helper logic
    // ************************************
    localparam int BUSY_CYCLES = 1536;
    logic [11:0] fill_cnt_reg;
    logic unmapped;
    // Unaligned or beyond the last register
    assign unmapped = (paddr > `FMT_SRDIV_OFF) || (paddr[1:0] != 2'b00);
    // Cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_cnt_reg <= 12'h000;
        end else if (fill_cnt_reg != 12'hfff) begin
            fill_cnt_reg <= fill_cnt_reg + 12'h001;
        end
    end
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ************************************
    // Assertions
    // ************************************
    AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_UNMAPPED: assert property (psel && penable && unmapped |-> pslverr)
        else $error("unmapped access not refused");
    AST_NO_ERR_MAPPED: assert property (psel && penable && !unmapped |-> !pslverr)
        else $error("mapped access refused");
    AST_ERR_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read not zero");
    AST_STREAM_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample) && $stable(out_freq))
        else $error("stream word changed while stalled");
    AST_NO_SAMPLE_BUSY: assert property (fill_cnt_reg < BUSY_CYCLES |-> !out_valid)
        else $error("sample during table fill");
endmodule

bind fmtone_osc fmtone_osc_monitor #(.FIFO_DEPTH(FIFO_DEPTH), .FRAC_BITS(FRAC_BITS)) u_mon (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_valid(out_valid), .out_ready(out_ready),
    .out_sample(out_sample), .out_freq(out_freq));

// [verilog/fmtone_fifo.sv]
// Small valid/ready FIFO for oscillator output words
`timescale 1ns/10ps
module fmtone_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshakes and flags
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [verilog/fmtone_map.svh]
// Register offsets, field positions, reset values and timing counts of the FM tone oscillator
// Behaviour
// - FM output steps cyclically through one of six selectable tables.
// - Tables rewritten by a table load are used instead of default waves.
// - Sample 8000h drives wave frequency minus delta.
// - Sample 7fffh drives wave frequency plus delta.
// - Sample 0000h leaves wave frequency exactly at centre.
// - A tone start command loads table position from start point.
// - Start point ffffh keeps the current table position.
// - Rate sets full-table traversal per sample; 8000_0000h gives half a pass per sample.
// - Phase increment has deep fraction for very slow sweeps.
// - Triangle table: minimum at position 192, peak at 64.
// - Start position picks initial rising or falling sweep via table slope.
// - The output sample is scaled by the single gain register before the FIFO.
// - Synthesized samples of tables 0 to 4 span the full signal range; table 5 fills with zero.
// - FM enable one modulates; zero holds wave frequency constant.
`ifndef FMTONE_MAP_SVH
`define FMTONE_MAP_SVH

// ************************************
// Register offsets
// ************************************
`define FMT_CTRL_OFF 12'h000
`define FMT_CENTER_OFF 12'h004
`define FMT_DELTA_OFF 12'h008
`define FMT_RATE_OFF 12'h00c
`define FMT_START_OFF 12'h010
`define FMT_CMD_OFF 12'h014
`define FMT_TBLADDR_OFF 12'h018
`define FMT_TBLDATA_OFF 12'h01c
`define FMT_GAIN_OFF 12'h020
`define FMT_STATUS_OFF 12'h024
`define FMT_FREQ_OFF 12'h028
`define FMT_SAMPLE_OFF 12'h02c
`define FMT_SRDIV_OFF 12'h030

// ************************************
// Field positions and constants
// ************************************
`define FMT_CTRL_EN_BIT 0
`define FMT_CTRL_TBL_LSB 1
`define FMT_CMD_GO_BIT 0
`define FMT_CMD_RESTORE_BIT 1
`define FMT_START_KEEP 16'hffff
`define FMT_TBL_COUNT 6
`define FMT_TBL_DEPTH 256
`define FMT_TRI_MIN_POS 8'hc0
`define FMT_TRI_PEAK_POS 8'h40
`define FMT_GAIN_UNITY 16'h4000
`define FMT_CTRL_RST 32'h0000_0000
`define FMT_GAIN_RST 16'h4000
`define FMT_SRDIV_RST 32'h0000_1e84

`endif

// [verilog/fmtone_osc.sv]
// FM oscillator with table memory, gain stage and APB register slave
`timescale 1ns/10ps
`include "fmtone_map.svh"
module fmtone_osc #(
    parameter int FIFO_DEPTH = 4,
    parameter int FRAC_BITS = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample stream out
    output logic out_valid,
    input wire logic out_ready,
    output logic [15:0] out_sample,
    output logic [31:0] out_freq
);
    // ************************************
    // Declarations
    // ************************************
    localparam int PW = 8 + FRAC_BITS;
    logic [15:0] tbl_mem [`FMT_TBL_COUNT * `FMT_TBL_DEPTH];
    logic [31:0] ctrl_reg;
    logic [31:0] center_reg;
    logic [31:0] delta_reg;
    logic [31:0] rate_reg;
    logic [15:0] start_reg;
    logic [15:0] gain_reg;
    logic [31:0] srdiv_reg;
    logic [31:0] srcnt_reg;
    logic [10:0] tbl_addr_reg;
    logic [PW-1:0] phase_reg;
    logic [31:0] freq_reg;
    logic [15:0] sample_reg;
    logic tick_reg;
    logic cmd_pend_reg;
    logic [10:0] fill_idx_reg;
    fmtone_pkg::fmtone_state_t state_reg;
    fmtone_pkg::fmtone_out_t fifo_in;
    fmtone_pkg::fmtone_out_t fifo_out;
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic [2:0] tbl_sel;
    logic [15:0] tbl_word;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic busy;

    // Default waveform value for a table at a position; full-scale shapes for tables 0 to 4, zero for table 5
    function automatic logic [15:0] fmt_default(input logic [2:0] tbl, input logic [7:0] pos);
        logic [15:0] tri_v;
        logic [15:0] saw_v;
        logic [7:0] q;
        tri_v = 16'h0000;
        saw_v = {pos, pos} ^ 16'h8000;
        q = pos - `FMT_TRI_MIN_POS;
        // Rising from 192 to 64, falling from 64 to 192
        if (q < 8'h80) begin
            tri_v = {q[6:0], q[6:0], 2'b00} ^ 16'h8000;
        end else begin
            tri_v = ~({q[6:0], q[6:0], 2'b00} ^ 16'h8000);
        end
        case (tbl)
            3'h0: fmt_default = pos[7] ? ~tri_v ^ 16'hffff ^ 16'h0000 : tri_v;
            3'h1: fmt_default = pos[7] ? 16'h8000 : 16'h7fff;
            3'h2: fmt_default = tri_v;
            3'h3: fmt_default = saw_v;
            3'h4: fmt_default = ~saw_v;
            default: fmt_default = 16'h0000;
        endcase
    endfunction

    // ************************************
    // APB register access
    // ************************************
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign busy = (state_reg != fmtone_pkg::FMT_RUN);
    assign addr_ok = (paddr <= `FMT_SRDIV_OFF) && (paddr[1:0] == 2'b00);
    assign tbl_sel = ctrl_reg[`FMT_CTRL_TBL_LSB +: 3];

    // Answer in the access cycle, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // Read data captured in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            case (paddr)
                `FMT_CTRL_OFF: prdata <= ctrl_reg;
                `FMT_CENTER_OFF: prdata <= center_reg;
                `FMT_DELTA_OFF: prdata <= delta_reg;
                `FMT_RATE_OFF: prdata <= rate_reg;
                `FMT_START_OFF: prdata <= {16'h0000, start_reg};
                `FMT_TBLADDR_OFF: prdata <= {21'h000000, tbl_addr_reg};
                `FMT_GAIN_OFF: prdata <= {16'h0000, gain_reg};
                `FMT_STATUS_OFF: prdata <= {busy, cmd_pend_reg, 6'h00, phase_reg[PW-1 -: 8], 16'h0000};
                `FMT_FREQ_OFF: prdata <= freq_reg;
                `FMT_SAMPLE_OFF: prdata <= {16'h0000, sample_reg};
                `FMT_SRDIV_OFF: prdata <= srdiv_reg;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `FMT_CTRL_RST;
            center_reg <= 32'h0000_0000;
            delta_reg <= 32'h0000_0000;
            rate_reg <= 32'h0000_0000;
            start_reg <= `FMT_START_KEEP;
            gain_reg <= `FMT_GAIN_RST;
            srdiv_reg <= `FMT_SRDIV_RST;
        end else if (apb_wr && pready) begin
            case (paddr)
                `FMT_CTRL_OFF: ctrl_reg <= {28'h0000000, pwdata[3:0]};
                `FMT_CENTER_OFF: center_reg <= pwdata;
                `FMT_DELTA_OFF: delta_reg <= pwdata;
                `FMT_RATE_OFF: rate_reg <= pwdata;
                `FMT_START_OFF: start_reg <= pwdata[15:0];
                `FMT_GAIN_OFF: gain_reg <= pwdata[15:0];
                `FMT_SRDIV_OFF: srdiv_reg <= (pwdata == 32'h0) ? 32'h1 : pwdata;
                default: ;
            endcase
        end
    end

    // ************************************
    // Table memory and rewrite sequencing
    // ************************************
    // Table pointer auto-increments on data writes; restore refills defaults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbl_addr_reg <= 11'h000;
            fill_idx_reg <= 11'h000;
            state_reg <= fmtone_pkg::FMT_FILL;
        end else begin
            case (state_reg)
                fmtone_pkg::FMT_RUN: begin
                    if (apb_wr && pready && paddr == `FMT_TBLADDR_OFF) begin
                        tbl_addr_reg <= pwdata[10:0];
                    end else if (apb_wr && pready && paddr == `FMT_TBLDATA_OFF) begin
                        tbl_addr_reg <= tbl_addr_reg + 11'h001;
                        state_reg <= fmtone_pkg::FMT_LOAD;
                    end else if (apb_wr && pready && paddr == `FMT_CMD_OFF && pwdata[`FMT_CMD_RESTORE_BIT]) begin
                        fill_idx_reg <= 11'h000;
                        state_reg <= fmtone_pkg::FMT_FILL;
                    end
                end
                fmtone_pkg::FMT_LOAD: state_reg <= fmtone_pkg::FMT_RUN;
                fmtone_pkg::FMT_FILL: begin
                    fill_idx_reg <= fill_idx_reg + 11'h001;
                    if (fill_idx_reg == 11'(`FMT_TBL_COUNT * `FMT_TBL_DEPTH - 1)) begin
                        state_reg <= fmtone_pkg::FMT_RUN;
                    end
                end
                default: state_reg <= fmtone_pkg::FMT_RUN;
            endcase
        end
    end

    // Memory writes: default fill or host rewrite
    always_ff @(posedge pclk) begin
        if (state_reg == fmtone_pkg::FMT_FILL) begin
            tbl_mem[fill_idx_reg] <= fmt_default(fill_idx_reg[10:8], fill_idx_reg[7:0]);
        end else if (apb_wr && pready && paddr == `FMT_TBLDATA_OFF && !busy &&
                     tbl_addr_reg < 11'(`FMT_TBL_COUNT * `FMT_TBL_DEPTH)) begin
            tbl_mem[tbl_addr_reg] <= pwdata[15:0];
        end
    end

    // Modulation sample from the selected table
    // Table codes past the last table read zero instead of unwritten memory
    assign tbl_word = (tbl_sel < 3'(`FMT_TBL_COUNT)) ? tbl_mem[{tbl_sel, phase_reg[PW-1 -: 8]}] : 16'h0000;

    // ************************************
    // Sample rate and oscillator
    // ************************************
    // Sample-rate enable from divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srcnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (srcnt_reg + 32'h1 >= srdiv_reg) begin
                srcnt_reg <= 32'h0000_0000;
                tick_reg <= !busy;
            end else begin
                srcnt_reg <= srcnt_reg + 32'h1;
            end
        end
    end

    // Tone start command held until next sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_pend_reg <= 1'b0;
        end else if (apb_wr && pready && paddr == `FMT_CMD_OFF && pwdata[`FMT_CMD_GO_BIT]) begin
            cmd_pend_reg <= 1'b1;
        end else if (tick_reg) begin
            cmd_pend_reg <= 1'b0;
        end
    end

    // Phase accumulator: rate is table passes per sample with fraction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= '0;
        end else if (tick_reg) begin
            if (cmd_pend_reg && start_reg != `FMT_START_KEEP) begin
                phase_reg <= {start_reg[7:0], {FRAC_BITS{1'b0}}};
            end else if (ctrl_reg[`FMT_CTRL_EN_BIT]) begin
                phase_reg <= phase_reg + PW'(rate_reg);
            end
        end
    end

    // Instantaneous wave frequency and modulation sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_reg <= 32'h0000_0000;
            sample_reg <= 16'h0000;
        end else if (tick_reg) begin
            sample_reg <= tbl_word;
            if (ctrl_reg[`FMT_CTRL_EN_BIT]) begin
                // centre + delta*s/32768; 8000h gives -delta, 7fffh exactly +delta
                freq_reg <= fmt_mod(center_reg, delta_reg, tbl_word);
            end else begin
                freq_reg <= center_reg;
            end
        end
    end

    // Signed scaling of delta by table sample
    function automatic logic [31:0] fmt_mod(input logic [31:0] c, input logic [31:0] d, input logic [15:0] s);
        logic signed [49:0] prod;
        logic signed [49:0] off;
        prod = $signed({1'b0, d, 1'b0}) * $signed(s);
        off = (s == 16'h7fff) ? 50'($signed({1'b0, d})) : (prod >>> 16);
        fmt_mod = c + off[31:0];
    endfunction

    // ************************************
    // Gain stage and output FIFO
    // ************************************
    // Track gain, unity at 4000h, saturating
    function automatic logic [15:0] fmt_gain(input logic [15:0] s, input logic [15:0] g);
        logic signed [32:0] p;
        p = ($signed(s) * $signed({1'b0, g})) >>> 14;
        if (p > 33'sd32767) begin
            fmt_gain = 16'h7fff;
        end else if (p < -33'sd32768) begin
            fmt_gain = 16'h8000;
        end else begin
            fmt_gain = p[15:0];
        end
    endfunction

    // Gained sample and frequency travel together as one FIFO word
    assign fifo_in = {fmt_gain(sample_reg, gain_reg), freq_reg};

    // Push one word per sample; request held while FIFO full, next sample replaces it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_in_valid <= 1'b0;
        end else begin
            fifo_in_valid <= tick_reg || (fifo_in_valid && !fifo_in_ready);
        end
    end

    fmtone_fifo #(
        .WIDTH($bits(fmtone_pkg::fmtone_out_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        // Pop exactly when the output register loads, so no word is shown twice
        .out_ready(!out_valid || out_ready),
        .out_data(fifo_out)
    );

    // Registered stream output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_sample <= 16'h0000;
            out_freq <= 32'h0000_0000;
        end else if (!out_valid || out_ready) begin
            out_valid <= fifo_out_valid;
            out_sample <= fifo_out.sample;
            out_freq <= fifo_out.freq;
        end
    end
endmodule

// [verilog/fmtone_pkg.sv]
// Types shared by the FM tone oscillator
package fmtone_pkg;
    // Mixer output word handed to the FIFO
    typedef struct packed {
        logic [15:0] sample;
        logic [31:0] freq;
    } fmtone_out_t;

    // Table rewrite sequencing
    typedef enum logic [2:0] {
        FMT_RUN = 3'b001,
        FMT_FILL = 3'b010,
        FMT_LOAD = 3'b100
    } fmtone_state_t;
endpackage
